//--- iox_map.svh
// Constants for the I/O expander serial register port: register offsets,
// power-up values, configuration bit positions and bus framing counts.
// Assumes it is included by the package and by each file that uses its macros.
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// Register offsets (command byte values)
`define IOX_REG_INPUT   8'h00
`define IOX_REG_BLINK0  8'h01
`define IOX_REG_DIR     8'h03
`define IOX_REG_BLINK1  8'h09
`define IOX_REG_MASTER  8'h0E
`define IOX_REG_CONFIG  8'h0F
`define IOX_REG_INT10   8'h10
`define IOX_REG_INT32   8'h11
`define IOX_REG_INT54   8'h12
`define IOX_REG_INT76   8'h13

// Power-up values
`define IOX_RST_BLINK   8'hFF
`define IOX_RST_DIR     8'hFF
`define IOX_RST_MASTER  8'h0F
`define IOX_RST_CONFIG  6'h0C
`define IOX_RST_INTENS  8'hFF

// Configuration register layout: D5..D0 stored, D6 reads zero, D7 flag
`define IOX_CFG_STORE_W 6
`define IOX_CFG_D6      1'h0

// Strap connection codes on each two-bit strap input
`define IOX_STRAP_GND   2'h0
`define IOX_STRAP_VCC   2'h1
`define IOX_STRAP_SCL   2'h2
`define IOX_STRAP_SDA   2'h3

// Framing
`define IOX_BYTE_BITS   4'h8
`define IOX_FIRST_BIT   4'h1
`define IOX_IDX_ADDR    2'h0
`define IOX_IDX_CMD     2'h1
`define IOX_IDX_DATA    2'h2
`define IOX_UNMAPPED    8'h00

`endif

//--- iox_pkg.sv
// Types and shared helper functions of the I/O expander serial port.
// Assumes the constant header is on the include path.
package iox_pkg;
`include "iox_map.svh"

  // Serial engine states
  typedef enum logic [2:0] {
    IOX_IDLE, IOX_RX, IOX_RACK, IOX_TX, IOX_TACK
  } iox_state_e;

  // Pointer advance after each data byte: fixed registers hold,
  // intensity group circulates 0x10..0x13
  function automatic logic [7:0] iox_next_ptr(input logic [7:0] p);
    case (p)
      `IOX_REG_INT10: iox_next_ptr = `IOX_REG_INT32;
      `IOX_REG_INT32: iox_next_ptr = `IOX_REG_INT54;
      `IOX_REG_INT54: iox_next_ptr = `IOX_REG_INT76;
      `IOX_REG_INT76: iox_next_ptr = `IOX_REG_INT10;
      default:        iox_next_ptr = p;
    endcase
  endfunction

  // Slave address from strap codes; bit 1 of a code marks a bus line,
  // bit 0 marks supply or data line
  function automatic logic [6:0] iox_strap_addr(input logic [1:0] hi,
                                                input logic [1:0] mid,
                                                input logic [1:0] lo);
    iox_strap_addr[6] = hi[1];
    iox_strap_addr[2] = hi[0];
    iox_strap_addr[5] = ~mid[1];
    iox_strap_addr[4] = mid[1];
    iox_strap_addr[1] = mid[0];
    iox_strap_addr[3] = lo[1];
    iox_strap_addr[0] = lo[0];
  endfunction
endpackage

//--- iox_sync.sv
// Two-flop synchroniser for signals arriving from outside the clock domain.
// Assumes the inputs are independent levels; multi-bit words are not coherent.
`timescale 1ns/1ps
module iox_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;      // First stage, read only by the second
  logic [W-1:0] next_meta; // Next first stage
  logic [W-1:0] next_out;  // Next second stage

  // Next values
  always_comb begin
    next_meta = async_in;
    next_out  = meta;
  end

  // No reset: true levels are already in place when reset releases
  always_ff @(posedge clk) begin
    meta     <= next_meta;
    sync_out <= next_out;
  end
endmodule

//--- iox_change_detect.sv
// Transition detector: compares live port levels against a stored sample.
// Assumes live levels are already synchronised to clk.
`timescale 1ns/1ps
module iox_change_detect #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Live levels, direction (1 = input) and resample strobe
  input  wire logic [W-1:0] live,
  input  wire logic [W-1:0] direction,
  input  wire logic         resample,
  // Interrupt condition
  output logic              irq_flag
);
  logic [W-1:0] sample;      // Compared snapshot
  logic         primed;      // Snapshot taken since reset
  logic [W-1:0] next_sample; // Next snapshot
  logic         next_primed; // Next primed
  logic         next_irq;    // Next interrupt condition

  // Snapshot on the first cycle after reset and on each resample request;
  // the compare uses the snapshot regardless of direction history, so a
  // port turned to input compares against a stale value
  always_comb begin
    next_primed = 1'b1;
    next_sample = sample;
    if (!primed || resample) begin
      next_sample = live;
    end
    // Self-clearing: only a live mismatch on an input holds the flag
    next_irq = primed && !resample && |((live ^ sample) & direction);
  end

  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sample   <= '0;
      primed   <= 1'b0;
      irq_flag <= 1'b0;
    end else begin
      sample   <= next_sample;
      primed   <= next_primed;
      irq_flag <= next_irq;
    end
  end
endmodule

//--- iox_serial_port.sv
// Serial-slave register port of an 8-port I/O expander.
// Assumes SCL and SDA arrive from an external master at a rate well below
// clk/8; straps are static two-bit connection codes.
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_serial_port #(
  parameter int PORTS = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Serial bus pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // Address straps (connection codes)
  input  wire logic [1:0]       addr_strap_high,
  input  wire logic [1:0]       addr_strap_mid,
  input  wire logic [1:0]       addr_strap_low,
  // Port pin levels
  input  wire logic [PORTS-1:0] port_levels,
  // Register contents for the output logic
  output logic      [7:0]       blink_phase0_outputs,
  output logic      [PORTS-1:0] port_direction,
  output logic      [7:0]       blink_phase1_outputs,
  output logic      [7:0]       master_and_aux_intensity,
  output logic      [`IOX_CFG_STORE_W-1:0] device_configuration,
  output logic      [7:0]       intensity_ports_1_0,
  output logic      [7:0]       intensity_ports_3_2,
  output logic      [7:0]       intensity_ports_5_4,
  output logic      [7:0]       intensity_ports_7_6,
  // Interrupt condition
  output logic                  irq_flag
);
  import iox_pkg::*;

  // Synchronised pins
  logic [1:0]       bus_s;     // {scl, sda}
  logic [5:0]       strap_s;   // {high, mid, low}
  logic [PORTS-1:0] ports_s;   // Port levels
  logic             scl_s;     // Synchronised clock line
  logic             sda_s;     // Synchronised data line

  // Edge history and decoded bus events
  logic             scl_d;     // Previous clock line
  logic             sda_d;     // Previous data line
  logic             scl_rise;  // Clock rising
  logic             scl_fall;  // Clock falling
  logic             bus_start; // Start or repeated start
  logic             bus_stop;  // Stop

  // Engine state
  iox_state_e       state;     // Serial engine state
  logic [3:0]       bit_cnt;   // Bits moved in this byte
  logic [7:0]       shift;     // Byte shifter
  logic [1:0]       byte_idx;  // Address, command or data byte
  logic             is_read;   // Direction of this transfer
  logic             master_ack; // Master acknowledged last byte
  logic [7:0]       ptr;       // Stored command byte
  logic [6:0]       slave_addr; // Strap-decoded address

  // Next values
  iox_state_e       next_state;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       next_shift;
  logic [1:0]       next_byte_idx;
  logic             next_is_read;
  logic             next_master_ack;
  logic [7:0]       next_ptr;
  logic             next_sda_oe;
  logic [6:0]       next_slave_addr;
  logic [7:0]       next_blink0;
  logic [PORTS-1:0] next_dir;
  logic [7:0]       next_blink1;
  logic [7:0]       next_master;
  logic [`IOX_CFG_STORE_W-1:0] next_config;
  logic [7:0]       next_int10;
  logic [7:0]       next_int32;
  logic [7:0]       next_int54;
  logic [7:0]       next_int76;

  // Strobes inside one cycle
  logic             do_write;  // Store received data byte at pointer
  logic             do_load;   // Fetch byte at pointer for transmit
  logic             resample;  // Refresh the transition snapshot
  logic [7:0]       rd_byte;   // Register selected by pointer

  // Pin synchronisers; the bus lines must settle before edge detection
  iox_sync #(.W(2)) u_bus_sync (
    .clk      (clk),
    .async_in ({scl_in, sda_in}),
    .sync_out (bus_s)
  );

  iox_sync #(.W(6)) u_strap_sync (
    .clk      (clk),
    .async_in ({addr_strap_high, addr_strap_mid, addr_strap_low}),
    .sync_out (strap_s)
  );

  iox_sync #(.W(PORTS)) u_port_sync (
    .clk      (clk),
    .async_in (port_levels),
    .sync_out (ports_s)
  );

  // Transition detection on ports marked as inputs
  iox_change_detect #(.W(PORTS)) u_change (
    .clk       (clk),
    .reset     (reset),
    .live      (ports_s),
    .direction (port_direction),
    .resample  (resample),
    .irq_flag  (irq_flag)
  );

  // Bus event decode from synchronised lines
  always_comb begin
    scl_s     = bus_s[1];
    sda_s     = bus_s[0];
    scl_rise  = scl_s && !scl_d;
    scl_fall  = !scl_s && scl_d;
    bus_start = scl_s && scl_d && sda_d && !sda_s;
    bus_stop  = scl_s && scl_d && !sda_d && sda_s;
  end

  // Read mux; unmapped offsets return a fixed filler byte
  always_comb begin
    case (ptr)
      `IOX_REG_INPUT:  rd_byte = ports_s;
      `IOX_REG_BLINK0: rd_byte = blink_phase0_outputs;
      `IOX_REG_DIR:    rd_byte = port_direction;
      `IOX_REG_BLINK1: rd_byte = blink_phase1_outputs;
      `IOX_REG_MASTER: rd_byte = master_and_aux_intensity;
      // Flag in D7, D6 reads zero, rest as written
      `IOX_REG_CONFIG: rd_byte = {irq_flag, `IOX_CFG_D6, device_configuration};
      `IOX_REG_INT10:  rd_byte = intensity_ports_1_0;
      `IOX_REG_INT32:  rd_byte = intensity_ports_3_2;
      `IOX_REG_INT54:  rd_byte = intensity_ports_5_4;
      `IOX_REG_INT76:  rd_byte = intensity_ports_7_6;
      default:         rd_byte = `IOX_UNMAPPED;
    endcase
  end

  // Serial engine: start and stop override any state so a broken frame
  // never leaves the data line held low
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_byte_idx   = byte_idx;
    next_is_read    = is_read;
    next_master_ack = master_ack;
    next_ptr        = ptr;
    next_sda_oe     = sda_oe;
    next_slave_addr = iox_strap_addr(strap_s[5:4], strap_s[3:2], strap_s[1:0]);
    do_write        = 1'b0;
    do_load         = 1'b0;
    if (bus_start) begin
      // Fresh frame; the pointer survives a repeated start
      next_state    = IOX_RX;
      next_bit_cnt  = '0;
      next_byte_idx = `IOX_IDX_ADDR;
      next_sda_oe   = 1'b0;
    end else if (bus_stop) begin
      // Stop after the command byte leaves only the pointer changed
      next_state  = IOX_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        IOX_IDLE: begin
          next_sda_oe = 1'b0;
        end
        IOX_RX: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + `IOX_FIRST_BIT;
          end else if (scl_fall && bit_cnt == `IOX_BYTE_BITS) begin
            // Byte complete: acknowledge on this falling edge
            next_state  = IOX_RACK;
            next_sda_oe = 1'b1;
            case (byte_idx)
              `IOX_IDX_ADDR: begin
                if (shift[7:1] == slave_addr) begin
                  next_is_read  = shift[0];
                  next_byte_idx = `IOX_IDX_CMD;
                end else begin
                  // Not ours: stay off the bus until the next start
                  next_state  = IOX_IDLE;
                  next_sda_oe = 1'b0;
                end
              end
              `IOX_IDX_CMD: begin
                next_ptr      = shift;
                next_byte_idx = `IOX_IDX_DATA;
              end
              default: begin
                do_write = 1'b1;
                next_ptr = iox_next_ptr(ptr);
              end
            endcase
          end
        end
        IOX_RACK: begin
          if (scl_fall) begin
            if (is_read) begin
              do_load = 1'b1;
            end else begin
              next_sda_oe  = 1'b0;
              next_bit_cnt = '0;
              next_state   = IOX_RX;
            end
          end
        end
        IOX_TX: begin
          if (scl_fall) begin
            if (bit_cnt == `IOX_BYTE_BITS) begin
              // Release for the master's acknowledge
              next_sda_oe = 1'b0;
              next_state  = IOX_TACK;
            end else begin
              next_shift   = {shift[6:0], 1'b0};
              next_sda_oe  = ~shift[6];
              next_bit_cnt = bit_cnt + `IOX_FIRST_BIT;
            end
          end
        end
        IOX_TACK: begin
          if (scl_rise) begin
            next_master_ack = ~sda_s;
          end else if (scl_fall) begin
            if (master_ack) begin
              do_load = 1'b1;
            end else begin
              next_state = IOX_IDLE;
            end
          end
        end
        default: begin
          next_state  = IOX_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    if (do_load) begin
      // Present the pointed register MSB first, then advance
      next_shift   = rd_byte;
      next_sda_oe  = ~rd_byte[7];
      next_bit_cnt = `IOX_FIRST_BIT;
      next_ptr     = iox_next_ptr(ptr);
      next_state   = IOX_TX;
    end
  end

  // Register writes; a write at the input register offset is dropped
  always_comb begin
    next_blink0 = blink_phase0_outputs;
    next_dir    = port_direction;
    next_blink1 = blink_phase1_outputs;
    next_master = master_and_aux_intensity;
    next_config = device_configuration;
    next_int10  = intensity_ports_1_0;
    next_int32  = intensity_ports_3_2;
    next_int54  = intensity_ports_5_4;
    next_int76  = intensity_ports_7_6;
    // Reading the input register latches the levels and the snapshot
    resample    = do_load && ptr == `IOX_REG_INPUT;
    if (do_write) begin
      case (ptr)
        `IOX_REG_BLINK0: next_blink0 = shift;
        `IOX_REG_DIR:    next_dir    = shift;
        `IOX_REG_BLINK1: next_blink1 = shift;
        `IOX_REG_MASTER: next_master = shift;
        `IOX_REG_CONFIG: begin
          // D7 is status only; the write also takes a fresh snapshot
          next_config = shift[`IOX_CFG_STORE_W-1:0];
          resample    = 1'b1;
        end
        `IOX_REG_INT10:  next_int10  = shift;
        `IOX_REG_INT32:  next_int32  = shift;
        `IOX_REG_INT54:  next_int54  = shift;
        `IOX_REG_INT76:  next_int76  = shift;
        default:         next_blink0 = blink_phase0_outputs;
      endcase
    end
  end

  // Registers; power-up makes every port an input, PWM and blink off
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d                    <= 1'b1;
      sda_d                    <= 1'b1;
      state                    <= IOX_IDLE;
      bit_cnt                  <= '0;
      shift                    <= '0;
      byte_idx                 <= `IOX_IDX_ADDR;
      is_read                  <= 1'b0;
      master_ack               <= 1'b0;
      ptr                      <= `IOX_REG_INPUT;
      sda_oe                   <= 1'b0;
      sda_out                  <= 1'b0;
      slave_addr               <= '0;
      blink_phase0_outputs     <= `IOX_RST_BLINK;
      port_direction           <= `IOX_RST_DIR;
      blink_phase1_outputs     <= `IOX_RST_BLINK;
      master_and_aux_intensity <= `IOX_RST_MASTER;
      device_configuration     <= `IOX_RST_CONFIG;
      intensity_ports_1_0      <= `IOX_RST_INTENS;
      intensity_ports_3_2      <= `IOX_RST_INTENS;
      intensity_ports_5_4      <= `IOX_RST_INTENS;
      intensity_ports_7_6      <= `IOX_RST_INTENS;
    end else begin
      scl_d                    <= scl_s;
      sda_d                    <= sda_s;
      state                    <= next_state;
      bit_cnt                  <= next_bit_cnt;
      shift                    <= next_shift;
      byte_idx                 <= next_byte_idx;
      is_read                  <= next_is_read;
      master_ack               <= next_master_ack;
      ptr                      <= next_ptr;
      sda_oe                   <= next_sda_oe;
      sda_out                  <= 1'b0; // Open drain: only ever pulls low
      slave_addr               <= next_slave_addr;
      blink_phase0_outputs     <= next_blink0;
      port_direction           <= next_dir;
      blink_phase1_outputs     <= next_blink1;
      master_and_aux_intensity <= next_master;
      device_configuration     <= next_config;
      intensity_ports_1_0      <= next_int10;
      intensity_ports_3_2      <= next_int32;
      intensity_ports_5_4      <= next_int54;
      intensity_ports_7_6      <= next_int76;
    end
  end
endmodule

//--- iox_serial_port_sva.sv
// Assertions on the serial register port, watching its ports only.
// Assumes bus clock phases of at least four clk cycles.
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_serial_port_sva #(
  parameter int PORTS = 8
) (
  // Clock, reset and bus
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  // Straps and port levels
  input wire logic [1:0]       addr_strap_high,
  input wire logic [1:0]       addr_strap_mid,
  input wire logic [1:0]       addr_strap_low,
  input wire logic [PORTS-1:0] port_levels,
  // Register contents and flag
  input wire logic [7:0]       blink_phase0_outputs,
  input wire logic [PORTS-1:0] port_direction,
  input wire logic [7:0]       blink_phase1_outputs,
  input wire logic [7:0]       master_and_aux_intensity,
  input wire logic [`IOX_CFG_STORE_W-1:0] device_configuration,
  input wire logic [7:0]       intensity_ports_1_0,
  input wire logic [7:0]       intensity_ports_3_2,
  input wire logic [7:0]       intensity_ports_5_4,
  input wire logic [7:0]       intensity_ports_7_6,
  input wire logic             irq_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Reset checks must run while reset is high, so they drop the default
  a_reset_state: assert property (disable iff (1'b0) reset |=> !sda_oe &&
    port_direction == 8'hFF && blink_phase0_outputs == 8'hFF && blink_phase1_outputs == 8'hFF
    && master_and_aux_intensity == 8'h0F && device_configuration == 6'h0C
    && intensity_ports_1_0 == 8'hFF && intensity_ports_7_6 == 8'hFF)
    else $error("register state wrong after reset");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq_flag)
    else $error("interrupt flag set after reset");
  // Only ports set as inputs may raise the flag
  a_irq_inputs: assert property (irq_flag |-> $past(port_direction) != 8'h00)
    else $error("interrupt flag with no input port");
  // Drive changes land a few cycles after a clock fall, never near a rise
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in &&
    ($past(scl_in, 2) || $past(scl_in, 3) || $past(scl_in, 4)))
    else $error("data drive changed away from a clock fall");
  a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  // Registers change only during the acknowledge of a data byte
  a_write_at_ack: assert property ($changed({blink_phase0_outputs, port_direction,
    blink_phase1_outputs, master_and_aux_intensity, device_configuration,
    intensity_ports_1_0, intensity_ports_3_2, intensity_ports_5_4,
    intensity_ports_7_6}) |-> sda_oe) else $error("register changed outside an ack");
  a_one_reg: assert property ($onehot0({$changed(blink_phase0_outputs),
    $changed(port_direction), $changed(blink_phase1_outputs),
    $changed(master_and_aux_intensity), $changed(device_configuration),
    $changed(intensity_ports_1_0), $changed(intensity_ports_3_2),
    $changed(intensity_ports_5_4), $changed(intensity_ports_7_6)}))
    else $error("two registers changed at once");
  // A configuration write resamples the ports, so the flag drops
  a_cfg_resample: assert property ($changed(device_configuration) |-> ##[0:1] !irq_flag)
    else $error("flag survived a configuration write");
  c_irq: cover property ($rose(irq_flag));
  c_ack: cover property ($rose(sda_oe));
  c_dir: cover property ($changed(port_direction));
endmodule

bind iox_serial_port iox_serial_port_sva #(.PORTS(PORTS)) u_iox_serial_port_sva (.*);

//--- iox_bus_master.sv
// Two-wire bus master model: drives the clock and an open-drain data line.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module iox_bus_master (
  // Clock and bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  int slow = 0;  // Extra low-phase cycles for a slow master
  // Both lines rest released; the bus clock stands still between frames
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // Every pin change lands just after a clk edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data set mid-low so it never moves near a clock edge
  task automatic bit_io(input logic b, output logic r);
    tick(2 + slow);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
  endtask
  // Start, or repeated start when the clock is low
  task automatic start();
    tick(2);
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // Eight bits most significant first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

//--- iox_serial_port_tb.sv
// Bench for the serial register port: frames from the master model.
// Assumes the checker and master model are compiled first.
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_serial_port_tb;
  logic        clk;
  logic        reset;
  logic        scl;
  logic        sda_drv;
  logic        sda_oe;
  logic        sda;
  logic [1:0]  addr_strap_high;
  logic [1:0]  addr_strap_mid;
  logic [1:0]  addr_strap_low;
  logic [7:0]  port_levels;
  logic [7:0]  blink_phase0_outputs;
  logic [7:0]  port_direction;
  logic [7:0]  blink_phase1_outputs;
  logic [7:0]  master_and_aux_intensity;
  logic [5:0]  device_configuration;
  logic [7:0]  intensity_ports_1_0;
  logic [7:0]  intensity_ports_3_2;
  logic [7:0]  intensity_ports_5_4;
  logic [7:0]  intensity_ports_7_6;
  logic        irq_flag;
  logic [69:0] regs;       // All stored registers, configuration last
  logic [6:0]  dev;        // Slave address expected from the straps
  logic [7:0]  q;
  logic        ack;
  int          error_cnt = 0;
  int          num_checks = 0;
  localparam logic [69:0] RST = {64'hFFFF_FF0F_FFFF_FFFF, 6'h0C};
  // Open drain with pull-up: low while anyone pulls
  assign sda = sda_drv & ~sda_oe;
  assign regs = {blink_phase0_outputs, port_direction, blink_phase1_outputs,
                 master_and_aux_intensity, intensity_ports_1_0, intensity_ports_3_2,
                 intensity_ports_5_4, intensity_ports_7_6, device_configuration};
  iox_serial_port #(.PORTS(8)) u_iox_serial_port (.*, .scl_in(scl), .sda_in(sda), .sda_out());
  iox_bus_master u_iox_bus_master (.clk, .sda, .scl, .sda_drv);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [69:0] got, input logic [69:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Address from strap codes: a bus-line strap sets the upper bits
  function automatic logic [6:0] exp_addr(input logic [1:0] h, m, l);
    logic hb, mb, lb;
    hb = (h == `IOX_STRAP_SCL) || (h == `IOX_STRAP_SDA);
    mb = (m == `IOX_STRAP_SCL) || (m == `IOX_STRAP_SDA);
    lb = (l == `IOX_STRAP_SCL) || (l == `IOX_STRAP_SDA);
    exp_addr = {hb, ~mb, mb, lb, h == `IOX_STRAP_VCC || h == `IOX_STRAP_SDA,
                m == `IOX_STRAP_VCC || m == `IOX_STRAP_SDA,
                l == `IOX_STRAP_VCC || l == `IOX_STRAP_SDA};
  endfunction
  task automatic put(input logic [7:0] d);
    u_iox_bus_master.xfer(d, 1'b1, q, ack);
    check(ack, 1'b0);
  endtask
  // Command byte, then n bytes counting up from d
  task automatic wr(input logic [7:0] r, input logic [7:0] d, input int n);
    u_iox_bus_master.start();
    put({dev, 1'b0});
    put(r);
    for (int i = 0; i < n; i++) put(d + 8'(i));
    u_iox_bus_master.stop();
  endtask
  // Read from the stored pointer; the last byte is refused
  task automatic rd_now(input logic [7:0] e [$]);
    u_iox_bus_master.start();
    put({dev, 1'b1});
    foreach (e[i]) begin
      u_iox_bus_master.xfer(8'hFF, i == e.size() - 1, q, ack);
      check(q, e[i]);
    end
    u_iox_bus_master.stop();
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e [$]);
    u_iox_bus_master.start();
    put({dev, 1'b0});
    put(r);
    rd_now(e);
  endtask
  // Flag settles within a few cycles of the synchronisers
  task automatic irq_is(input logic v);
    for (int i = 0; i < 20 && irq_flag !== v; i++) @(posedge clk);
    check(irq_flag, v);
  endtask
  initial begin
    #1_500_000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    port_levels = 8'h3C;
    {addr_strap_high, addr_strap_mid, addr_strap_low} = 6'h00;
    dev = exp_addr(2'h0, 2'h0, 2'h0);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    check(regs, RST);
    check(irq_flag, 1'b0);
    rd(8'h0F, '{8'h0C});
    // Input register ignores writes and reads the pins twice over
    wr(8'h00, 8'h33, 2);
    check(regs, RST);
    rd(8'h00, '{8'h3C, 8'h3C});
    // Every strap combination: own address acked, neighbour refused
    for (int s = 0; s < 64; s++) begin
      @(posedge clk);
      {addr_strap_high, addr_strap_mid, addr_strap_low} <= 6'(s);
      repeat (4) @(posedge clk);
      dev = exp_addr(2'(s >> 4), 2'(s >> 2), 2'(s));
      u_iox_bus_master.start();
      u_iox_bus_master.xfer({dev ^ 7'h01, 1'b0}, 1'b1, q, ack);
      check(ack, 1'b1);
      u_iox_bus_master.start();
      put({dev, 1'b0});
      u_iox_bus_master.stop();
    end
    // Five bytes into the intensity group wrap onto the first one
    wr(8'h10, 8'hA0, 5);
    check(regs[37:6], 32'hA4A1A2A3);
    rd(8'h12, '{8'hA2, 8'hA3, 8'hA4, 8'hA1});
    // Fixed registers keep the pointer: the second byte overwrites
    for (int i = 0; i < 4; i++) begin
      logic [7:0] r;
      r = (i == 0) ? 8'h01 : (i == 1) ? 8'h03 : (i == 2) ? 8'h09 : 8'h0E;
      wr(r, {r[3:0], 4'h0}, 2);
      rd(r, '{{r[3:0], 4'h1}, {r[3:0], 4'h1}});
    end
    check(regs[69:38], 32'h113191E1);
    // Command byte alone moves only the pointer, read by a slow master
    u_iox_bus_master.slow = 6;
    wr(8'h09, 8'h00, 0);
    check(blink_phase1_outputs, 8'h91);
    rd_now('{8'h91});
    u_iox_bus_master.slow = 0;
    // Transition detection on inputs
    wr(8'h03, 8'hFF, 1);
    @(posedge clk);
    port_levels <= 8'h3D;
    irq_is(1'b1);
    rd(8'h0F, '{8'h8C});
    port_levels <= 8'h3C;
    irq_is(1'b0);
    port_levels <= 8'h7C;
    irq_is(1'b1);
    rd(8'h00, '{8'h7C});
    irq_is(1'b0);
    wr(8'h03, 8'hBF, 1);
    port_levels <= 8'h3C;
    repeat (8) @(posedge clk);
    irq_is(1'b0);
    wr(8'h03, 8'hFF, 1);
    irq_is(1'b1);
    wr(8'h0F, 8'hFF, 1);
    irq_is(1'b0);
    check(device_configuration, 6'h3F);
    rd(8'h0F, '{8'h3F});
    end_of_test();
  end
endmodule
